// ==== src/fclc_top.sv ====
// Flash command launch controller with option byte load and AXI4-Lite registers.
// Assumes one clock, async active-low reset, an option read port to flash.
// Overview of operation
// - option register readable, writes ignored
// - option byte loaded from flash at reset
// - double-bit fault sets option all ones
// - reserved test registers read zero
// - divider write sets loaded flag
// - unloaded divider refuses program/erase, access error
// - busy blocks launch and command writes
// - writing one clears completion and launches
// - completion held low until command ends
// - verify codes accepted in every mode
// - mass erase, unsecure only special modes
// - backdoor key only normal single chip
// - field margin only unsecured special
// - sector erase codes restricted mode set
// - common codes unsecured or secured NS
// - command code in high byte word 0
// - unimplemented indices ignore writes, read zero
`timescale 1ns/1ps
`include "fclc_defs.svh"
module fclc_top #(
    parameter int unsigned EXEC_CYCLES = 4
) (
    // Clock, reset, enable
    input  wire logic           sys_clk_i,
    input  wire logic           rst_n_i,
    input  wire logic           clk_en_i,
    // AXI4-Lite write channels
    input  wire logic [7:0]     s_axi_awaddr_i,
    input  wire logic           s_axi_awvalid_i,
    output logic                s_axi_awready_o,
    input  wire logic [31:0]    s_axi_wdata_i,
    input  wire logic [3:0]     s_axi_wstrb_i,
    input  wire logic           s_axi_wvalid_i,
    output logic                s_axi_wready_o,
    output logic [1:0]          s_axi_bresp_o,
    output logic                s_axi_bvalid_o,
    input  wire logic           s_axi_bready_i,
    // AXI4-Lite read channels
    input  wire logic [7:0]     s_axi_araddr_i,
    input  wire logic           s_axi_arvalid_i,
    output logic                s_axi_arready_o,
    output logic [31:0]         s_axi_rdata_o,
    output logic [1:0]          s_axi_rresp_o,
    output logic                s_axi_rvalid_o,
    input  wire logic           s_axi_rready_i,
    // Option byte read port toward flash
    output logic                opt_rd_req_o,
    output logic [22:0]         opt_rd_addr_o,
    input  wire logic           opt_rd_ack_i,
    input  wire logic [7:0]     opt_rd_data_i,
    input  wire logic           opt_rd_dbe_i,
    // Launched command toward memory controller
    output logic                cmd_launch_o,
    output logic [15:0]         cmd_word0_o
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        fclc_pkg::fclc_state_t fsm;
        logic [7:0]  option_bits;
        logic [6:0]  divider_ratio_field;
        logic        divider_loaded_flag;
        logic        command_complete_flag;
        logic        access_error_flag;
        logic        protection_violation_flag;
        logic [2:0]  command_object_index;
        logic [95:0] ccob;
        logic        secured;
        logic [1:0]  mode;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        opt_req;
        logic        launch;
        logic        exec_start;
    } fclc_top_st_t;
    fclc_top_st_t st_r;
    fclc_top_st_t st_nxt;
    logic         exec_done;
    fclc_cmd_if   cmd_bus ();
    // ****************************************************************
    // Submodules
    // ****************************************************************
    fclc_cmd_gate u_gate (
        .cmd (cmd_bus.gate)
    );
    fclc_exec #(.EXEC_CYCLES(EXEC_CYCLES)) u_exec (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .clk_en_i  (clk_en_i),
        .start_i   (st_r.exec_start),
        .done_o    (exec_done)
    );
    // code from high byte word 0
    assign cmd_bus.code    = st_r.ccob[15:8];
    assign cmd_bus.secured = st_r.secured;
    assign cmd_bus.mode    = fclc_pkg::fclc_mode_t'(st_r.mode);
    // ****************************************************************
    // Read decode
    // ****************************************************************
    function automatic logic [32:0] fclc_read(input fclc_top_st_t s, input logic [7:0] a);
        logic [15:0] w;
        w = 16'h0000;
        if (s.command_object_index < 3'(`FCLC_CCOB_WORDS)) begin
            w = s.ccob[16*s.command_object_index +: 16];
        end
        case (a)
            `FCLC_OFF_CLKDIV: fclc_read = {1'b1, 24'h0, s.divider_loaded_flag,
                                           s.divider_ratio_field};
            `FCLC_OFF_STATUS: fclc_read = {1'b1, 24'h0, s.command_complete_flag, 1'b0,
                                           s.access_error_flag, s.protection_violation_flag,
                                           4'h0};
            `FCLC_OFF_COMMAND_OBJECT_INDEX: fclc_read = {1'b1, 29'h0, s.command_object_index};
            `FCLC_OFF_CCOB:   fclc_read = {1'b1, 16'h0, w};
            `FCLC_OFF_MODE:   fclc_read = {1'b1, 29'h0, s.secured, s.mode};
            `FCLC_OFF_OPTION: fclc_read = {1'b1, 24'h0, s.option_bits};
            `FCLC_OFF_RSV_B, 8'(`FCLC_IDX_RSV_C * 4), 8'(`FCLC_IDX_RSV_D * 4):
                fclc_read = {1'b1, 32'h0};
            default:          fclc_read = {1'b0, 32'h0};
        endcase
    endfunction
    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic        wr_fire;
        logic [32:0] rd;
        logic        hit;
        wr_fire = 1'b0;
        rd      = 33'h0;
        hit     = 1'b1;
        st_nxt  = st_r;
        st_nxt.launch     = 1'b0;
        st_nxt.exec_start = 1'b0;
        // Channel capture, either order
        if (s_axi_awvalid_i && !st_r.aw_got && !st_r.bvalid) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !st_r.w_got && !st_r.bvalid) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.w_data = s_axi_wdata_i;
            st_nxt.w_strb = s_axi_wstrb_i;
        end
        if (st_r.bvalid && s_axi_bready_i) begin
            st_nxt.bvalid = 1'b0;
        end
        wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
        case (st_r.fsm)
            fclc_pkg::FCLC_LOADOPT: begin
                st_nxt.opt_req = 1'b1;
                if (st_r.opt_req && opt_rd_ack_i) begin
                    st_nxt.opt_req = 1'b0;
                    st_nxt.fsm     = fclc_pkg::FCLC_IDLE;
                    st_nxt.option_bits = opt_rd_dbe_i ? `FCLC_OPT_FAULT : opt_rd_data_i;
                end
            end
            fclc_pkg::FCLC_IDLE: begin
            end
            fclc_pkg::FCLC_BUSY: begin
                if (exec_done) begin
                    st_nxt.command_complete_flag = 1'b1;
                    st_nxt.fsm                   = fclc_pkg::FCLC_IDLE;
                end
            end
            default: st_nxt.fsm = fclc_pkg::FCLC_IDLE;
        endcase
        // Register writes; ignore writes by omission
        if (wr_fire) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            rd  = fclc_read(st_r, st_r.aw_addr);
            hit = rd[32];
            st_nxt.bresp = hit ? `FCLC_RESP_OKAY : `FCLC_RESP_SLVERR;
            if (st_r.w_strb[0]) begin
                case (st_r.aw_addr)
                    `FCLC_OFF_CLKDIV: begin
                        st_nxt.divider_ratio_field = st_r.w_data[6:0];
                        st_nxt.divider_loaded_flag = 1'b1;
                    end
                    `FCLC_OFF_STATUS: begin
                        if (st_r.w_data[`FCLC_ACCESS_ERROR_FLAG_BIT]) begin
                            st_nxt.access_error_flag = 1'b0;
                        end
                        if (st_r.w_data[`FCLC_PROTECTION_VIOLATION_FLAG_BIT]) begin
                            st_nxt.protection_violation_flag = 1'b0;
                        end
                        if (st_r.w_data[`FCLC_COMMAND_COMPLETE_FLAG_BIT] && st_r.command_complete_flag &&
                            st_r.fsm == fclc_pkg::FCLC_IDLE &&
                            !st_r.access_error_flag && !st_r.protection_violation_flag) begin
                            if (!cmd_bus.allowed ||
                                (cmd_bus.prog_erase && !st_r.divider_loaded_flag)) begin
                                st_nxt.access_error_flag = 1'b1;
                            end else begin
                                st_nxt.command_complete_flag = 1'b0;
                                st_nxt.launch                = 1'b1;
                                st_nxt.exec_start            = 1'b1;
                                st_nxt.fsm                   = fclc_pkg::FCLC_BUSY;
                            end
                        end
                    end
                    `FCLC_OFF_COMMAND_OBJECT_INDEX: st_nxt.command_object_index = st_r.w_data[2:0];
                    `FCLC_OFF_MODE: begin
                        st_nxt.mode    = st_r.w_data[1:0];
                        st_nxt.secured = st_r.w_data[2];
                    end
                    default: begin
                    end
                endcase
            end
            if (st_r.aw_addr == `FCLC_OFF_CCOB && st_r.command_complete_flag &&
                st_r.command_object_index < 3'(`FCLC_CCOB_WORDS)) begin
                for (int b = 0; b < 2; b++) begin
                    if (st_r.w_strb[b]) begin
                        st_nxt.ccob[16*st_r.command_object_index + 8*b +: 8] =
                            st_r.w_data[8*b +: 8];
                    end
                end
            end
        end
        // Read channel, one outstanding
        if (st_r.rvalid && s_axi_rready_i) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && !st_r.rvalid) begin
            rd            = fclc_read(st_r, s_axi_araddr_i);
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd[31:0];
            st_nxt.rresp  = rd[32] ? `FCLC_RESP_OKAY : `FCLC_RESP_SLVERR;
        end
    end
    // ****************************************************************
    // State register
    // ****************************************************************
    // Completion flag resets high so software may launch once the option byte is loaded
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
            st_r.fsm <= fclc_pkg::FCLC_LOADOPT;
            st_r.command_complete_flag <= 1'b1;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end
    // Outputs straight from flops
    assign s_axi_awready_o = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready_o  = !st_r.w_got && !st_r.bvalid;
    assign s_axi_bvalid_o  = st_r.bvalid;
    assign s_axi_bresp_o   = st_r.bresp;
    assign s_axi_arready_o = !st_r.rvalid;
    assign s_axi_rvalid_o  = st_r.rvalid;
    assign s_axi_rdata_o   = st_r.rdata;
    assign s_axi_rresp_o   = st_r.rresp;
    assign opt_rd_req_o    = st_r.opt_req;
    assign opt_rd_addr_o   = `FCLC_OPT_ADDR;
    assign cmd_launch_o    = st_r.launch;
    assign cmd_word0_o     = st_r.ccob[15:0];
    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_launch_clears;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && st_r.launch) |-> !st_r.command_complete_flag;
    endproperty
    a_launch_clears: assert property (p_launch_clears) else $error("launch with flag set");
    property p_busy_low;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (st_r.fsm == fclc_pkg::FCLC_BUSY) |-> !st_r.command_complete_flag;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("flag high while busy");
    property p_opt_fault;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && st_r.fsm == fclc_pkg::FCLC_LOADOPT && st_r.opt_req && opt_rd_ack_i
         && opt_rd_dbe_i) |=> (st_r.option_bits == `FCLC_OPT_FAULT);
    endproperty
    a_opt_fault: assert property (p_opt_fault) else $error("fault not all ones");
    property p_opt_stable;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (st_r.fsm != fclc_pkg::FCLC_LOADOPT) |=> $stable(st_r.option_bits);
    endproperty
    a_opt_stable: assert property (p_opt_stable) else $error("option byte changed");
    property p_nodiv;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (st_r.launch && cmd_bus.prog_erase) |-> st_r.divider_loaded_flag;
    endproperty
    a_nodiv: assert property (p_nodiv) else $error("launch without divider");
    property p_gate;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        st_r.launch |-> cmd_bus.allowed;
    endproperty
    a_gate: assert property (p_gate) else $error("refused code launched");
    property p_lock;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (!st_r.command_complete_flag && !st_r.exec_start) |=> $stable(st_r.ccob);
    endproperty
    a_lock: assert property (p_lock) else $error("command words changed busy");
    property p_divld;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        st_r.divider_loaded_flag |=> st_r.divider_loaded_flag;
    endproperty
    a_divld: assert property (p_divld) else $error("loaded flag dropped");
    property p_done;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && st_r.fsm == fclc_pkg::FCLC_BUSY && exec_done)
        |=> st_r.command_complete_flag;
    endproperty
    a_done: assert property (p_done) else $error("completion not set");
endmodule // fclc_top

// ==== src/fclc_defs.svh ====
// Offsets, field positions, reset values and constants of the flash launch block.
// Assumes inclusion by bare name from each design file.
`ifndef FCLC_DEFS_SVH
`define FCLC_DEFS_SVH
// ****************************************************************
// Register byte offsets and word indices
// ****************************************************************
`define FCLC_OFF_CLKDIV   8'h00
`define FCLC_OFF_STATUS   8'h04
`define FCLC_OFF_COMMAND_OBJECT_INDEX   8'h08
`define FCLC_OFF_CCOB     8'h0c
`define FCLC_OFF_MODE     8'h10
`define FCLC_OFF_OPTION   8'h14
`define FCLC_OFF_RSV_B    8'h18
`define FCLC_IDX_RSV_C    8'h12
`define FCLC_IDX_RSV_D    8'h13
// ****************************************************************
// Field positions
// ****************************************************************
`define FCLC_DIVLD_BIT    7
`define FCLC_COMMAND_COMPLETE_FLAG_BIT     7
`define FCLC_ACCESS_ERROR_FLAG_BIT   5
`define FCLC_PROTECTION_VIOLATION_FLAG_BIT   4
// ****************************************************************
// Reset values and constants
// ****************************************************************
`define FCLC_OPT_ADDR     23'h7fff0e
`define FCLC_OPT_FAULT    8'hff
`define FCLC_CCOB_WORDS   6
`define FCLC_RESP_OKAY    2'b00
`define FCLC_RESP_SLVERR  2'b10
`endif

// ==== src/fclc_pkg.sv ====
// Types shared by the flash launch block.
// Assumes nothing beyond a SystemVerilog compiler.
package fclc_pkg;
    // Operating mode index; the secured flag is kept apart
    typedef enum logic [1:0] {
        FCLC_NS,
        FCLC_NX,
        FCLC_SS,
        FCLC_ST
    } fclc_mode_t;
    // Launch controller states
    typedef enum logic [1:0] {
        FCLC_LOADOPT,
        FCLC_IDLE,
        FCLC_BUSY
    } fclc_state_t;
endpackage

// ==== src/fclc_cmd_if.sv ====
// Launch handshake carrier between the controller and the command gate.
// Assumes both ends on sys_clk_i.
`timescale 1ns/1ps
interface fclc_cmd_if;
    logic [7:0]         code;
    logic               secured;
    fclc_pkg::fclc_mode_t mode;
    logic               allowed;
    logic               prog_erase;
    modport ctrl (output code, output secured, output mode, input allowed, input prog_erase);
    modport gate (input code, input secured, input mode, output allowed, output prog_erase);
endinterface

// ==== src/fclc_cmd_gate.sv ====
// Command permission table by security state and operating mode.
// Assumes a purely combinational use by the launch controller.
`timescale 1ns/1ps
module fclc_cmd_gate (
    // Launch request view
    fclc_cmd_if.gate    cmd
);
    // ****************************************************************
    // Permission decode
    // ****************************************************************
    function automatic logic fclc_permit(input logic [7:0] c, input logic s,
                                         input fclc_pkg::fclc_mode_t m);
        logic special;
        special = (m == fclc_pkg::FCLC_SS) || (m == fclc_pkg::FCLC_ST);
        case (c)
            8'h01, 8'h02: fclc_permit = 1'b1;
            8'h08, 8'h0b: fclc_permit = special;
            8'h0c: fclc_permit = (m == fclc_pkg::FCLC_NS);
            8'h0e: fclc_permit = !s && special;
            8'h0a, 8'h10, 8'h12: fclc_permit = s ? (m == fclc_pkg::FCLC_NS)
                                                 : (m != fclc_pkg::FCLC_NS);
            8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0d, 8'h11:
                fclc_permit = !s || (m == fclc_pkg::FCLC_NS);
            default: fclc_permit = 1'b0;
        endcase
    endfunction
    // Table lookup and program/erase class
    always_comb begin
        cmd.allowed    = fclc_permit(cmd.code, cmd.secured, cmd.mode);
        cmd.prog_erase = (cmd.code inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
                                           8'h0b, 8'h11, 8'h12});
    end
endmodule // fclc_cmd_gate

// ==== src/fclc_exec.sv ====
// Stand-in execution engine: finishes a launched command after a fixed delay.
// Assumes the real algorithms sit behind this handshake.
`timescale 1ns/1ps
module fclc_exec #(
    parameter int unsigned EXEC_CYCLES = 4
) (
    // Clock and reset
    input  wire logic   sys_clk_i,
    input  wire logic   rst_n_i,
    input  wire logic   clk_en_i,
    // Handshake
    input  wire logic   start_i,
    output logic        done_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       run;
        logic       done;
    } fclc_exec_st_t;
    fclc_exec_st_t st_r;
    fclc_exec_st_t st_nxt;
    // Countdown while running
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (start_i) begin
            st_nxt.run = 1'b1;
            st_nxt.cnt = 8'(EXEC_CYCLES);
        end else if (st_r.run) begin
            if (st_r.cnt <= 8'h01) begin
                st_nxt.run  = 1'b0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - 8'h01;
            end
        end
    end
    // State register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end
    assign done_o = st_r.done;
endmodule // fclc_exec

// ==== tb/flash_command_launch_control_test.sv ====
// Self-checking bench for the flash launch block, driven over AXI4-Lite.
// Assumes src/ on the include path; the bench answers the option fetch itself.
`timescale 1ns/1ps
`include "fclc_defs.svh"
module flash_command_launch_control_test;
    // ****************************************
    // Signals
    // ****************************************
    logic        clk, rst_n, awv, wv, arv, ack, acked, dbe, en;
    logic        awr, wrdy, bv, arr, rv, launch, oreq;
    logic [7:0]  awa, ara, odat, p;
    logic [31:0] wd, rd, rdat;
    logic [1:0]  rsp, br, rr;
    logic [22:0] oaddr;
    logic [15:0] w0;
    logic [7:0]  rsv   [3] = '{`FCLC_OFF_RSV_B, 8'h48, 8'h4c};
    logic [7:0]  codes [17] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09,
                                8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h05};
    int          n_fail = 0, total_checks = 0, n_launch = 0, cyc = 0;

    fclc_top #(.EXEC_CYCLES(20)) fclc_top_inst (
        .sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
        .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1),
        .opt_rd_req_o(oreq), .opt_rd_addr_o(oaddr), .opt_rd_ack_i(ack),
        .opt_rd_data_i(odat), .opt_rd_dbe_i(dbe), .cmd_launch_o(launch), .cmd_word0_o(w0));

    // Free-running bus clock
    // bus clock 10 MHz, above 1 MHz
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Option fetch answered once per reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            acked <= 1'b0;
        end else begin
            ack <= oreq && !acked && !ack;
            acked <= acked || ack;
        end
    end
    // Launch pulses counted; hang guard
    always @(posedge clk) begin
        if (launch === 1'b1) n_launch <= n_launch + 1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            test_done();
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Offer address and data together, release each when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        // No cycle count assumed; only the hang guard ends a stuck wait
        forever begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            if (bv === 1'b1) break;
        end
        rsp = br;
    endtask
    task automatic rdr(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        forever begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (rv === 1'b1) break;
        end
        rd = rdat;
        rsp = rr;
    endtask
    // Permitted modes per code: bit index is {secured, mode}
    function automatic logic [7:0] perm(input logic [7:0] c);
        case (c)
            8'h01, 8'h02: perm = 8'hff;
            8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0d, 8'h11: perm = 8'h1f;
            8'h08, 8'h0b: perm = 8'hcc;
            8'h0a, 8'h10, 8'h12: perm = 8'h1e;
            8'h0c: perm = 8'h11;
            8'h0e: perm = 8'h0c;
            default: perm = 8'h00;
        endcase
    endfunction
    // Load word 0, launch, then check busy, results and refusal
    task automatic launch_cmd(input logic [7:0] c, input logic ok);
        int n0;
        wr(`FCLC_OFF_COMMAND_OBJECT_INDEX, 32'h0);
        wr(`FCLC_OFF_CCOB, {16'h0, c, 8'h00});
        n0 = n_launch;
        wr(`FCLC_OFF_STATUS, 32'h80);
        rdr(`FCLC_OFF_STATUS);
        if (ok) begin
            chk(rd, 32'h0);
            wr(`FCLC_OFF_CCOB, 32'h1234);
            for (int k = 0; k < 40 && rd[7] !== 1'b1; k++) rdr(`FCLC_OFF_STATUS);
            chk(rd, 32'h80);
            rdr(`FCLC_OFF_CCOB);
            chk(rd, {16'h0, c, 8'h00});
            chk({16'h0, w0}, {16'h0, c, 8'h00});
        end else begin
            chk(rd, 32'ha0);
            wr(`FCLC_OFF_STATUS, 32'h20);
        end
        chk(32'(n_launch - n0), {31'h0, ok});
    endtask
    task automatic test_done();
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst_n, awv, wv, arv, dbe, en} = 6'h1;
        {awa, ara, wd} = 48'h0;
        odat = 8'h5a;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rdr(`FCLC_OFF_OPTION);
        chk(rd, 32'h5a);
        chk({9'h0, oaddr}, {9'h0, `FCLC_OPT_ADDR});
        wr(`FCLC_OFF_OPTION, 32'h33);
        chk({30'h0, rsp}, {30'h0, `FCLC_RESP_OKAY});
        rdr(`FCLC_OFF_OPTION);
        chk(rd, 32'h5a);
        foreach (rsv[i]) begin
            wr(rsv[i], 32'hff);
            rdr(rsv[i]);
            chk({rd[31:2], rd[1:0] | rsp}, 32'h0);
        end
        rdr(8'h40);
        chk({30'h0, rsp}, {30'h0, `FCLC_RESP_SLVERR});
        rdr(`FCLC_OFF_CLKDIV);
        chk(rd, 32'h0);
        wr(`FCLC_OFF_MODE, 32'h0);
        launch_cmd(8'h06, 1'b0);
        launch_cmd(8'h01, 1'b1);
        wr(`FCLC_OFF_CLKDIV, 32'h05);
        rdr(`FCLC_OFF_CLKDIV);
        chk(rd, 32'h85);
        wr(`FCLC_OFF_COMMAND_OBJECT_INDEX, 32'h0);
        wr(`FCLC_OFF_CCOB, 32'h0100);
        wr(`FCLC_OFF_STATUS, 32'h80);
        en <= 1'b0;
        repeat (40) @(posedge clk);
        en <= 1'b1;
        rdr(`FCLC_OFF_STATUS);
        chk(rd, 32'h0);
        for (int k = 0; k < 40 && rd[7] !== 1'b1; k++) rdr(`FCLC_OFF_STATUS);
        chk(rd, 32'h80);
        wr(`FCLC_OFF_COMMAND_OBJECT_INDEX, 32'h6);
        wr(`FCLC_OFF_CCOB, 32'hbeef);
        rdr(`FCLC_OFF_CCOB);
        chk(rd, 32'h0);
        // Every table code plus unlisted code 05 in every security state and mode
        for (int m = 0; m < 8; m++) begin
            wr(`FCLC_OFF_MODE, 32'(m));
            foreach (codes[i]) begin
                p = perm(codes[i]);
                launch_cmd(codes[i], p[m]);
            end
        end
        // Second reset with a double fault on the option fetch
        dbe <= 1'b1;
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rdr(`FCLC_OFF_OPTION);
        chk(rd, 32'hff);
        rdr(`FCLC_OFF_CLKDIV);
        chk(rd, 32'h0);
        test_done();
    end
endmodule // flash_command_launch_control_test
